// file: flash_block_lock_regs.sv
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "flash_lock_defs.svh"

// What this block does
// - After reset, load the high-space image into the high lock register.
// - High image is 64 bits; upper 32 bits ignored for locking.
// - High enable is read-only, set by password B2B22222 until reset.
// - High lock bits ignore writes while high enable is clear.
// - High lock bit at 1 blocks program and erase of its block.
// - High lock writes frozen after interlock until done, and while suspended.
// - Absent high blocks reset to 1 and ignore writes.
// - In the 544 KB variant high bits 11 to 6 read 1.
// - Reset returns every lock to its stored value; erased means locked.
// - After reset, load the secondary image into the secondary register.
// - Secondary image is 64 bits; upper 32 bits ignored for locking.
// - Secondary enable is read-only, set by password C3C33333 until reset.
// - Effective low/mid/test-shadow lock is primary OR secondary.
// - Secondary lock bits ignore writes unless secondary enable is set.
// - Test/shadow lock blocks program and erase; test erase always refused.
// - Mid bits map to sectors 7 and 6; low 5:0 to 5-0.
// - Secondary writes frozen after interlock until done, and while suspended.
// - Absent secondary blocks reset to 1 and discard writes.
// - In the 544 KB variant secondary low bits 15 to 6 read 1.
// - Factory image is all ones, so every lock defaults locked.
// - Multiple control bits written at once: only one changes.
module flash_block_lock_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic [63:0] high_lock_nv_image_i,
  input  wire logic [63:0] secondary_lock_nv_image_i,
  input  wire logic [15:0] prim_low_lock_i,
  input  wire logic [1:0]  primary_mid_lock_bits_i,
  input  wire logic        primary_test_shadow_lock_i,
  input  wire logic        interlock_i,
  input  wire logic        op_done_i,
  input  wire logic [11:0] sel_high_i,
  input  wire logic [15:0] sel_low_i,
  input  wire logic [1:0]  sel_mid_i,
  input  wire logic        sel_ts_i,
  input  wire logic        test_block_i,
  output logic      [11:0] high_lock_o,
  output logic      [15:0] low_lock_o,
  output logic      [1:0]  mid_lock_o,
  output logic             ts_lock_o,
  output logic             hv_pulse_o,
  output logic             lock_refuse_o,
  output logic             load_done_o
);

  // =====================================================
  // Declarations
  flash_lock_pkg::phase_t phase_r;
  flash_lock_pkg::phase_t phase_nxt;

  logic [31:0] high_block_lock_reg;
  logic [31:0] secondary_lowmid_lock_reg;
  logic        high_lock_write_status;
  logic        secondary_lock_write_status;
  logic [3:0]  ctrl_bits;
  logic        operation_complete_flag;

  logic        req;
  logic        sel_high;
  logic        sel_sec;
  logic        sel_ctrl;
  logic        mapped;
  logic        wr_stb;
  logic [31:0] bmask;
  logic [31:0] rdata;
  logic        frozen;
  logic        load;

  logic [31:0] wb_dat_r;
  logic        wb_ack_r;
  logic        wb_err_r;

  logic [15:0] low_eff;
  logic [1:0]  mid_eff;
  logic        ts_eff;
  logic [11:0] high_lock_bits;
  logic [15:0] secondary_low_lock_bits;
  logic [1:0]  secondary_mid_lock_bits;
  logic        secondary_test_shadow_lock;

  logic        hv_req;
  logic        hit_lock;
  logic        test_erase;
  logic        refuse;

  logic [11:0] high_lock_r;
  logic [15:0] low_lock_r;
  logic [1:0]  mid_lock_r;
  logic        ts_lock_r;
  logic        hv_pulse_r;
  logic        lock_refuse_r;
  logic        load_done_r;

  // =====================================================
  // Reset phase sequencer
  // One cycle after reset release the images are copied in. Locks read as
  // all ones until then, so nothing can be programmed during reset.
  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      flash_lock_pkg::LOAD_ST: phase_nxt = flash_lock_pkg::RUN_ST;
      flash_lock_pkg::RUN_ST:  phase_nxt = flash_lock_pkg::RUN_ST;
      default:                 phase_nxt = flash_lock_pkg::LOAD_ST;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= flash_lock_pkg::LOAD_ST;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign load = (phase_r == flash_lock_pkg::LOAD_ST);

  // =====================================================
  // Wishbone decode
  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_r && !wb_err_r;
  assign sel_high = (wb_adr_i == `OFS_HIGH);
  assign sel_sec  = (wb_adr_i == `OFS_SEC);
  assign sel_ctrl = (wb_adr_i == `OFS_CTRL);
  assign mapped   = sel_high || sel_sec || sel_ctrl;
  assign wr_stb   = req && wb_we_i && !load;
  assign bmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // frozen on pending interlock or suspend
  assign frozen = !operation_complete_flag || ctrl_bits[`CTRL_SUSPEND_REQUEST_BIT];

  // =====================================================
  // Lock registers
  // only the low image word reaches the locks
  lock_word #(
    .PASS  (`HIGH_PASS),
    .WMASK (`HIGH_WMASK),
    .FORCE (`HIGH_FORCE)
  ) u_high (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .load_i   (load),
    .nv_i     (high_lock_nv_image_i[31:0]),
    .wr_i     (wr_stb && sel_high),
    .wdata_i  (wb_dat_i),
    .bmask_i  (bmask),
    .frozen_i (frozen),
    .bits_o   (high_block_lock_reg),
    .en_o     (high_lock_write_status)
  );

  lock_word #(
    .PASS  (`SEC_PASS),
    .WMASK (`SEC_WMASK),
    .FORCE (`SEC_FORCE)
  ) u_sec (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .load_i   (load),
    .nv_i     (secondary_lock_nv_image_i[31:0]),
    .wr_i     (wr_stb && sel_sec),
    .wdata_i  (wb_dat_i),
    .bmask_i  (bmask),
    .frozen_i (frozen),
    .bits_o   (secondary_lowmid_lock_reg),
    .en_o     (secondary_lock_write_status)
  );

  ctrl_priority u_ctrl (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .wr_i        (wr_stb && sel_ctrl),
    .wdata_i     (wb_dat_i[3:0]),
    .interlock_i (interlock_i),
    .op_done_i   (op_done_i),
    .ctrl_o      (ctrl_bits),
    .done_o      (operation_complete_flag)
  );

  assign high_lock_bits             = high_block_lock_reg[11:0];
  assign secondary_low_lock_bits    = secondary_lowmid_lock_reg[15:0];
  assign secondary_mid_lock_bits    = secondary_lowmid_lock_reg[`MID_LSB+1:`MID_LSB];
  assign secondary_test_shadow_lock = secondary_lowmid_lock_reg[`TS_BIT];

  // =====================================================
  // Read mux
  always_comb begin
    rdata = 32'h00000000;
    if (sel_high) begin
      rdata = high_block_lock_reg;
      rdata[`EN_BIT] = high_lock_write_status;
    end else if (sel_sec) begin
      rdata = secondary_lowmid_lock_reg;
      rdata[`EN_BIT] = secondary_lock_write_status;
    end else if (sel_ctrl) begin
      rdata[3:0] = ctrl_bits;
      rdata[`CTRL_DONE] = operation_complete_flag;
    end
  end

  // Answer one cycle after the request; unmapped offsets get err
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_r <= 1'b0;
      wb_err_r <= 1'b0;
    end else begin
      wb_ack_r <= req && mapped;
      wb_err_r <= req && !mapped;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_r <= 32'h00000000;
    end else if (req && !wb_we_i) begin
      wb_dat_r <= rdata;
    end
  end

  // =====================================================
  // Effective locks
  // primary OR secondary, per sector
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_low
      assign low_eff[gi] = prim_low_lock_i[gi] | secondary_low_lock_bits[gi];
    end
  endgenerate

  assign mid_eff = primary_mid_lock_bits_i | secondary_mid_lock_bits;
  assign ts_eff  = primary_test_shadow_lock_i | secondary_test_shadow_lock;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_lock_r <= 12'hFFF;
      low_lock_r  <= 16'hFFFF;
      mid_lock_r  <= 2'h3;
      ts_lock_r   <= 1'b1;
    end else begin
      high_lock_r <= high_lock_bits;
      low_lock_r  <= low_eff;
      mid_lock_r  <= mid_eff;
      ts_lock_r   <= ts_eff;
    end
  end

  // =====================================================
  // High-voltage gating
  assign hv_req = ctrl_bits[`CTRL_EHV] && (ctrl_bits[`CTRL_ERS] || ctrl_bits[`CTRL_PGM]) &&
                  !ctrl_bits[`CTRL_SUSPEND_REQUEST_BIT];
  // any selected locked block refuses pulses
  assign hit_lock = |(sel_high_i & high_lock_bits) || |(sel_low_i & low_eff) ||
                    |(sel_mid_i & mid_eff) || (sel_ts_i && ts_eff);
  assign test_erase = ctrl_bits[`CTRL_ERS] && sel_ts_i && test_block_i;
  assign refuse     = hit_lock || test_erase || load;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hv_pulse_r    <= 1'b0;
      lock_refuse_r <= 1'b0;
    end else begin
      hv_pulse_r    <= hv_req && !refuse;
      lock_refuse_r <= hv_req && refuse;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_done_r <= 1'b0;
    end else if (load) begin
      load_done_r <= 1'b1;
    end
  end

  // =====================================================
  // Outputs
  assign wb_dat_o      = wb_dat_r;
  assign wb_ack_o      = wb_ack_r;
  assign wb_err_o      = wb_err_r;
  assign high_lock_o   = high_lock_r;
  assign low_lock_o    = low_lock_r;
  assign mid_lock_o    = mid_lock_r;
  assign ts_lock_o     = ts_lock_r;
  assign hv_pulse_o    = hv_pulse_r;
  assign lock_refuse_o = lock_refuse_r;
  assign load_done_o   = load_done_r;

  // =====================================================
  // Checks
  a_nv_load_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (load && !rst_i) |=> high_block_lock_reg[5:0] == $past(high_lock_nv_image_i[5:0]))
    else $error("high lock image not loaded");

  a_nv_load_sec: assert property (@(posedge clk_i) disable iff (rst_i)
    (load && !rst_i) |=> secondary_lowmid_lock_reg[5:0] == $past(secondary_lock_nv_image_i[5:0]))
    else $error("secondary lock image not loaded");

  a_high_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
    high_block_lock_reg[11:6] == 6'h3F)
    else $error("high fixed bits not one");

  a_sec_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
    secondary_lowmid_lock_reg[15:6] == 10'h3FF)
    else $error("secondary fixed bits not one");

  a_enable_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    secondary_lock_write_status |=> secondary_lock_write_status)
    else $error("secondary enable dropped");

  a_bad_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_stb && sel_high && wb_dat_i != `HIGH_PASS && !high_lock_write_status)
      |=> !high_lock_write_status)
    else $error("wrong password set enable");

  a_frozen_sec: assert property (@(posedge clk_i) disable iff (rst_i)
    (frozen && !load) |=> $stable(secondary_lowmid_lock_reg))
    else $error("secondary lock written while frozen");

  a_frozen_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (frozen && !load) |=> $stable(high_block_lock_reg))
    else $error("high lock written while frozen");

  a_eff_or: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 low_lock_r == $past(prim_low_lock_i | secondary_low_lock_bits))
    else $error("effective low lock not OR");

  a_hv_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
    hit_lock |=> !hv_pulse_r && (lock_refuse_r == $past(hv_req)))
    else $error("pulse applied to locked block");

  a_test_erase: assert property (@(posedge clk_i) disable iff (rst_i)
    test_erase |=> !hv_pulse_r)
    else $error("test block erase allowed");

  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_r |=> !wb_ack_r)
    else $error("ack held two cycles");

endmodule

// file: flash_lock_defs.svh
`ifndef FLASH_LOCK_DEFS_SVH
`define FLASH_LOCK_DEFS_SVH

// =====================================================
// Register offsets (byte addresses)
`define OFS_HIGH        8'h00
`define OFS_SEC         8'h04
`define OFS_CTRL        8'h08

// =====================================================
// Passwords and field layout
`define HIGH_PASS       32'hB2B22222
`define SEC_PASS        32'hC3C33333
`define EN_BIT          31
`define HIGH_WMASK      32'h0000003F
`define HIGH_FORCE      32'h00000FC0
`define SEC_WMASK       32'h0013003F
`define SEC_FORCE       32'h0000FFC0
`define TS_BIT          20
`define MID_LSB         16
`define ALL_LOCKED      32'hFFFFFFFF

// =====================================================
// Control register bits
`define CTRL_ERS        0
`define CTRL_PGM        1
`define CTRL_EHV        2
`define CTRL_SUSPEND_REQUEST_BIT       3
`define CTRL_DONE       8

`endif

// file: flash_lock_pkg.sv
package flash_lock_pkg;
  typedef enum logic [1:0] {
    LOAD_ST = 2'h0,
    RUN_ST  = 2'h1
  } phase_t;
endpackage

// file: lock_word.sv
`timescale 1ns/1ps
`include "flash_lock_defs.svh"

module lock_word #(
  parameter logic [31:0] PASS  = 32'h00000000,
  parameter logic [31:0] WMASK = 32'h00000000,
  parameter logic [31:0] FORCE = 32'h00000000
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        load_i,
  input  wire logic [31:0] nv_i,
  input  wire logic        wr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [31:0] bmask_i,
  input  wire logic        frozen_i,
  output logic      [31:0] bits_o,
  output logic             en_o
);
  localparam logic [31:0] LMASK = WMASK | FORCE;

  logic [31:0] bits_r;
  logic        en_r;
  logic        pass_hit;

  assign pass_hit = wr_i && (bmask_i == `ALL_LOCKED) && (wdata_i == PASS);
  assign bits_o   = bits_r;
  assign en_o     = en_r;

  // =====================================================
  // Enable status
  // password sets enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r <= 1'b0;
    end else if (pass_hit) begin
      en_r <= 1'b1;
    end
  end

  // =====================================================
  // Lock bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bits_r <= LMASK;
    // image low word, absent bits forced
    end else if (load_i) begin
      bits_r <= (nv_i | FORCE) & LMASK;
    end else if (wr_i && !pass_hit && en_r && !frozen_i) begin
      bits_r <= (((bits_r & ~bmask_i) | (wdata_i & bmask_i)) & WMASK) | FORCE;
    end
  end

  a_fixed_ones: assert property (@(posedge clk_i) disable iff (rst_i) (bits_r & FORCE) == FORCE)
    else $error("fixed lock bit cleared");
  a_locked_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (!en_r && !load_i) |=> $stable(bits_r))
    else $error("lock bits changed while disabled");
  a_pass_enable: assert property (@(posedge clk_i) disable iff (rst_i) pass_hit |=> en_r [*2])
    else $error("password did not set enable");
endmodule

// file: ctrl_priority.sv
`timescale 1ns/1ps
`include "flash_lock_defs.svh"

module ctrl_priority (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wr_i,
  input  wire logic [3:0] wdata_i,
  input  wire logic       interlock_i,
  input  wire logic       op_done_i,
  output logic      [3:0] ctrl_o,
  output logic            done_o
);
  logic [3:0] ctrl_r;
  logic [3:0] diff;
  logic [3:0] pick;
  logic       done_r;

  assign diff   = wdata_i ^ ctrl_r;
  assign ctrl_o = ctrl_r;
  assign done_o = done_r;

  // one bit changes, level order ERASE_REQUEST_BIT PGM EHV SUSPEND_REQUEST_BIT
  always_comb begin
    pick = 4'h0;
    if (diff[`CTRL_ERS]) begin
      pick[`CTRL_ERS] = 1'b1;
    end else if (diff[`CTRL_PGM]) begin
      pick[`CTRL_PGM] = 1'b1;
    end else if (diff[`CTRL_EHV]) begin
      pick[`CTRL_EHV] = 1'b1;
    end else if (diff[`CTRL_SUSPEND_REQUEST_BIT]) begin
      pick[`CTRL_SUSPEND_REQUEST_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= 4'h0;
    end else if (wr_i) begin
      ctrl_r <= ctrl_r ^ pick;
    end
  end

  // Completion wins over a new interlock in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_r <= 1'b1;
    end else if (op_done_i) begin
      done_r <= 1'b1;
    end else if (interlock_i) begin
      done_r <= 1'b0;
    end
  end

  a_one_bit_change: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_i |=> $countones(ctrl_r ^ $past(ctrl_r)) <= 1)
    else $error("more than one control bit changed");
endmodule

// file: flash_block_lock_regs_tb.sv
`timescale 1ns/1ps
`include "flash_lock_defs.svh"

module flash_block_lock_regs_tb;
  typedef struct packed {
    logic [7:0]  a;
    logic [3:0]  s;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } row_t;

  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        err;
  logic [63:0] nv_high;
  logic [63:0] nv_sec;
  logic [15:0] prim_low;
  logic [1:0]  prim_mid;
  logic        prim_ts;
  logic        interlock;
  logic        op_done;
  logic [11:0] sel_high;
  logic [15:0] sel_low;
  logic [1:0]  sel_mid;
  logic        sel_ts;
  logic        test_blk;
  logic [11:0] high_lock;
  logic [15:0] low_lock;
  logic [1:0]  mid_lock;
  logic        ts_lock;
  logic        hv;
  logic        refuse;
  logic        load_done;
  logic [31:0] rd;
  logic        er;
  int          errors;
  int          compares;
  row_t        rows [16];

  flash_block_lock_regs u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .high_lock_nv_image_i(nv_high), .secondary_lock_nv_image_i(nv_sec), .prim_low_lock_i(prim_low),
    .primary_mid_lock_bits_i(prim_mid), .primary_test_shadow_lock_i(prim_ts), .interlock_i(interlock),
    .op_done_i(op_done), .sel_high_i(sel_high), .sel_low_i(sel_low), .sel_mid_i(sel_mid),
    .sel_ts_i(sel_ts), .test_block_i(test_blk), .high_lock_o(high_lock), .low_lock_o(low_lock),
    .mid_lock_o(mid_lock), .ts_lock_o(ts_lock), .hv_pulse_o(hv), .lock_refuse_o(refuse),
    .load_done_o(load_done)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // =====================================================
  // Wishbone classic master
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    // No local limit: only the watchdog ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1 && err !== 1'b1);
    rd = rdat;
    er = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                       input logic [31:0] m, input logic [31:0] e);
    bus(1'b1, a, s, d);
    bus(1'b0, a, 4'hF, 32'h00000000);
    chk(rd & m, e);
  endtask

  task automatic wait_load();
    while (load_done !== 1'b1) begin
      @(posedge clk_i);
    end
    @(posedge clk_i);
  endtask

  task automatic pulse(input logic which);
    @(posedge clk_i);
    if (which) op_done <= 1'b1;
    else interlock <= 1'b1;
    @(posedge clk_i);
    op_done   <= 1'b0;
    interlock <= 1'b0;
  endtask

  // =====================================================
  // Watchdog: whole run is well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    report_and_stop();
  end

  initial begin
    errors = 0; compares = 0;
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wdat = 32'h00000000;
    nv_high = 64'hDEADBEEF00000A15; nv_sec = 64'h1234567800120029;
    prim_low = 16'h0000; prim_mid = 2'h0; prim_ts = 1'b0; interlock = 1'b0; op_done = 1'b0;
    sel_high = 12'h000; sel_low = 16'h0000; sel_mid = 2'h0; sel_ts = 1'b0; test_blk = 1'b0;
    rows = '{
      '{`OFS_HIGH, 4'hF, 32'hFFFFFFC0, 32'h80000FFF, 32'h00000FD5},
      '{`OFS_HIGH, 4'hF, 32'hB2B22223, 32'h80000FFF, 32'h00000FD5},
      '{`OFS_HIGH, 4'h7, 32'hB2B22222, 32'h80000FFF, 32'h00000FD5},
      '{`OFS_HIGH, 4'hF, 32'hB2B22222, 32'h80000FFF, 32'h80000FD5},
      '{`OFS_HIGH, 4'hF, 32'h00000000, 32'h80000FFF, 32'h80000FC0},
      '{`OFS_HIGH, 4'h2, 32'hFFFFFFFF, 32'h80000FFF, 32'h80000FC0},
      '{`OFS_HIGH, 4'h1, 32'h7FFFFF2A, 32'h80000FFF, 32'h80000FEA},
      '{`OFS_SEC,  4'hF, 32'h00000000, 32'h8013FFFF, 32'h0012FFE9},
      '{`OFS_SEC,  4'hF, 32'hC3C33333, 32'h8013FFFF, 32'h8012FFE9},
      '{`OFS_SEC,  4'hF, 32'h00000000, 32'h8013FFFF, 32'h8000FFC0},
      '{`OFS_SEC,  4'hF, 32'h00130015, 32'h8013FFFF, 32'h8013FFD5},
      '{`OFS_CTRL, 4'hF, 32'h0000000F, 32'h0000010F, 32'h00000101},
      '{`OFS_CTRL, 4'hF, 32'h00000003, 32'h0000010F, 32'h00000103},
      '{`OFS_CTRL, 4'hF, 32'h00000000, 32'h0000010F, 32'h00000102},
      '{`OFS_CTRL, 4'hF, 32'h00000000, 32'h0000010F, 32'h00000100},
      '{`OFS_CTRL, 4'hF, 32'h00000000, 32'h0000010F, 32'h00000100}
    };
    repeat (12) @(posedge clk_i);
    chk({20'h00000, high_lock}, 32'h00000FFF);
    chk({31'h0, load_done}, 32'h00000000);
    rst_i <= 1'b0;
    wait_load();
    // Upper image halves carry junk on purpose
    chk({20'h00000, high_lock}, 32'h00000FD5);
    chk({16'h0000, low_lock}, 32'h0000FFE9);
    chk({29'h0, mid_lock, ts_lock}, 32'h00000005);

    // =====================================================
    // Table of register write/read pairs
    foreach (rows[i]) begin
      wr_rd(rows[i].a, rows[i].s, rows[i].d, rows[i].m, rows[i].e);
    end
    prim_low <= 16'h0008;
    repeat (3) @(posedge clk_i);
    chk({20'h00000, high_lock}, 32'h00000FEA);
    chk({16'h0000, low_lock}, 32'h0000FFDD);

    // =====================================================
    // Freeze after interlock and while suspended
    pulse(1'b0);
    wr_rd(`OFS_HIGH, 4'hF, 32'h0000003F, 32'h80000FFF, 32'h80000FEA);
    wr_rd(`OFS_SEC, 4'hF, 32'h00000000, 32'h8013FFFF, 32'h8013FFD5);
    bus(1'b0, `OFS_CTRL, 4'hF, 32'h00000000);
    chk(rd & 32'h00000100, 32'h00000000);
    pulse(1'b1);
    wr_rd(`OFS_HIGH, 4'hF, 32'h00000000, 32'h80000FFF, 32'h80000FC0);
    bus(1'b1, `OFS_CTRL, 4'hF, 32'h00000008);
    wr_rd(`OFS_HIGH, 4'hF, 32'h0000003F, 32'h80000FFF, 32'h80000FC0);
    wr_rd(`OFS_SEC, 4'hF, 32'h00000000, 32'h8013FFFF, 32'h8013FFD5);
    bus(1'b1, `OFS_CTRL, 4'hF, 32'h00000000);

    // =====================================================
    // High-voltage gating by effective locks
    sel_high <= 12'h001;
    bus(1'b1, `OFS_CTRL, 4'hF, 32'h00000002);
    bus(1'b1, `OFS_CTRL, 4'hF, 32'h00000006);
    repeat (3) @(posedge clk_i);
    chk({30'h0, hv, refuse}, 32'h00000002);
    bus(1'b1, `OFS_HIGH, 4'hF, 32'h00000001);
    repeat (3) @(posedge clk_i);
    chk({30'h0, hv, refuse}, 32'h00000001);
    sel_high <= 12'h000;
    sel_ts   <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({30'h0, hv, refuse}, 32'h00000001);
    bus(1'b1, `OFS_SEC, 4'hF, 32'h00000000);
    repeat (3) @(posedge clk_i);
    chk({30'h0, hv, refuse}, 32'h00000002);
    chk({16'h0000, low_lock}, 32'h0000FFC8);
    // Low and mid targets: primary lock alone must refuse
    sel_ts  <= 1'b0;
    sel_low <= 16'h0008;
    repeat (3) @(posedge clk_i);
    chk({30'h0, hv, refuse}, 32'h00000001);
    sel_low  <= 16'h0000;
    sel_mid  <= 2'h1;
    prim_mid <= 2'h1;
    repeat (3) @(posedge clk_i);
    chk({30'h0, hv, refuse}, 32'h00000001);
    chk({29'h0, mid_lock, ts_lock}, 32'h00000002);
    prim_mid <= 2'h0;
    repeat (3) @(posedge clk_i);
    chk({30'h0, hv, refuse}, 32'h00000002);
    sel_mid <= 2'h0;
    sel_ts  <= 1'b1;
    bus(1'b1, `OFS_CTRL, 4'hF, 32'h00000007);
    test_blk <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, refuse}, 32'h00000001);

    // =====================================================
    // Unmapped offset, then reset mid-run with erased images
    bus(1'b0, 8'h0C, 4'hF, 32'h00000000);
    chk({31'h0, er}, 32'h00000001);
    @(posedge clk_i);
    rst_i   <= 1'b1;
    nv_high <= 64'hFFFFFFFFFFFFFFFF;
    nv_sec  <= 64'hFFFFFFFFFFFFFFFF;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wait_load();
    bus(1'b0, `OFS_HIGH, 4'hF, 32'h00000000);
    chk(rd & 32'h80000FFF, 32'h00000FFF);
    bus(1'b0, `OFS_SEC, 4'hF, 32'h00000000);
    chk(rd & 32'h8013FFFF, 32'h0013FFFF);
    report_and_stop();
  end
endmodule
